/* include/wdc_defs.svh */
`ifndef WDC_DEFS_SVH
`define WDC_DEFS_SVH

// Special-function addresses
`define WDC_ADDR_CTRL 8'hD8
`define WDC_ADDR_KEY 8'hC7

// Control register field positions
`define WDC_BIT_RUN 7
`define WDC_BIT_RSVD 6
`define WDC_BIT_SEL_HI 5
`define WDC_BIT_SEL_LO 4
`define WDC_BIT_IRQ_FLAG 3
`define WDC_BIT_CAUSE 2
`define WDC_BIT_RST_EN 1
`define WDC_BIT_RESTART 0

// Power-on value of the control register
`define WDC_CTRL_RESET 8'h00

// Timed-access key bytes and open window in clocks
`define WDC_KEY_FIRST 8'hAA
`define WDC_KEY_SECOND 8'h55
`define WDC_KEY_WINDOW 3

// Delay from time-out to watchdog reset, in clocks
`define WDC_RST_DELAY_CLK 512

// Default time-out exponents, period is 2**n clocks
`define WDC_EXP_0 17
`define WDC_EXP_1 20
`define WDC_EXP_2 23
`define WDC_EXP_3 26

`endif

/* include/wdc_pkg.sv */
package wdc_pkg;

  typedef logic [7:0] wdc_byte_t;

  typedef enum logic [0:0] {
    WDC_COUNT,
    WDC_ARMED
  } wdc_state_e;

endpackage

/* hw/wdc_timer.sv */
`timescale 1ns/1ps
`include "wdc_defs.svh"

module wdc_timer
  import wdc_pkg::*;
#(
  parameter int EXP0 = `WDC_EXP_0,
  parameter int EXP1 = `WDC_EXP_1,
  parameter int EXP2 = `WDC_EXP_2,
  parameter int EXP3 = `WDC_EXP_3,
  parameter int DELAY = `WDC_RST_DELAY_CLK
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [1:0] sel,
  // Events
  output logic timeout,
  output logic expire
);

  localparam int CW = EXP3;
  localparam int DW = $clog2(DELAY + 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  wdc_state_e state_r;
  logic [CW-1:0] cnt_r;
  logic [DW-1:0] dly_r;

  function automatic int sel_exp(input logic [1:0] s);
    case (s)
      2'd0: sel_exp = EXP0;
      2'd1: sel_exp = EXP1;
      2'd2: sel_exp = EXP2;
      default: sel_exp = EXP3;
    endcase
  endfunction

  wire [CW-1:0] limit = (ONE << sel_exp(sel)) - ONE;
  wire hit = (cnt_r == limit);
  wire dly_done = (dly_r == DW'(DELAY - 1));

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= WDC_COUNT;
      cnt_r <= '0;
      dly_r <= '0;
      timeout <= 1'b0;
      expire <= 1'b0;
    end
    else
    begin
      timeout <= 1'b0;
      expire <= 1'b0;
      if (restart)
      begin
        state_r <= WDC_COUNT;
        cnt_r <= '0;
        dly_r <= '0;
      end
      else if (run)
      begin
        case (state_r)
          WDC_COUNT:
          begin
            if (hit)
            begin
              cnt_r <= '0;
              dly_r <= '0;
              timeout <= 1'b1;
              state_r <= WDC_ARMED;
            end
            else
            begin
              cnt_r <= cnt_r + ONE;
            end
          end
          WDC_ARMED:
          begin
            if (dly_done)
            begin
              expire <= 1'b1;
              state_r <= WDC_COUNT;
            end
            else
            begin
              dly_r <= dly_r + DW'(1);
            end
          end
          default:
          begin
            state_r <= WDC_COUNT;
          end
        endcase
      end
    end
  end

endmodule

/* hw/wdc_key_gate.sv */
`timescale 1ns/1ps
`include "wdc_defs.svh"

module wdc_key_gate
  import wdc_pkg::*;
#(
  parameter int WINDOW = `WDC_KEY_WINDOW
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Key register writes
  input wire logic key_wr,
  input wire wdc_byte_t wdata,
  // Protected write taken
  input wire logic consume,
  // Window state
  output logic open
);

  localparam int WW = $clog2(WINDOW + 1);

  logic first_r;
  logic [WW-1:0] win_r;

  wire is_first = (wdata == `WDC_KEY_FIRST);
  wire is_second = (wdata == `WDC_KEY_SECOND);

  assign open = (win_r != '0);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      first_r <= 1'b0;
      win_r <= '0;
    end
    else
    begin
      if (key_wr)
      begin
        first_r <= is_first;
      end
      if (key_wr && first_r && is_second)
      begin
        win_r <= WW'(WINDOW);
      end
      else if (consume)
      begin
        win_r <= '0;
      end
      else if (open)
      begin
        win_r <= win_r - WW'(1);
      end
    end
  end

endmodule

/* hw/wdc_top.sv */
`timescale 1ns/1ps
`include "wdc_defs.svh"

// Operation
// - Counter advances only while run bit 7 is set, halts otherwise.
// - Bits 5 and 4 select the time-out period.
// - Time-out sets interrupt flag bit 3 regardless of interrupt enable.
// - Watchdog reset sets reset-cause bit 2; it stays until software clears.
// - Power-on or power-fail reset clears the reset-cause bit.
// - With reset enable low, watchdog never touches the reset-cause bit.
// - Reset enable bit 1 allows or blocks the watchdog system reset.
// - Writing 1 to restart bit 0 returns the counter to zero.
// - Hardware clears the restart bit itself after the restart.
// - Time-out requests interrupt; 512 clocks later reset if enabled.
// - Control register powers up to its defined reset pattern.
// - External pin reset leaves the interrupt flag unchanged.
// - Reset enable is cleared only by power-on reset or a timed-access write.
// - Every control bit reads back freely at any time.
// - Reset enable, flag and restart need timed access; others write freely.
// - Control register sits at address D8h; bit 6 reserved, reads zero.
module wdc_top
  import wdc_pkg::*;
#(
  parameter int EXP0 = `WDC_EXP_0,
  parameter int EXP1 = `WDC_EXP_1,
  parameter int EXP2 = `WDC_EXP_2,
  parameter int EXP3 = `WDC_EXP_3,
  parameter int DELAY = `WDC_RST_DELAY_CLK,
  parameter int WINDOW = `WDC_KEY_WINDOW
)
(
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic rst,
  // Special-function register access
  input wire wdc_byte_t sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire wdc_byte_t sfr_wdata,
  output wdc_byte_t sfr_rdata,
  // Reset sources from pins
  input wire logic ext_reset_n,
  input wire logic power_fail,
  // Interrupt
  input wire logic watchdog_irq_enable,
  output logic watchdog_irq,
  // System reset request
  output logic watchdog_reset
);

  // Pin synchronisers
  logic ext_s1_r;
  logic ext_s2_r;
  logic pf_s1_r;
  logic pf_s2_r;

  // Control register fields
  logic watchdog_run_r;
  logic interval_select_hi_r;
  logic interval_select_lo_r;
  logic watchdog_irq_flag_r;
  logic watchdog_reset_cause_flag_r;
  logic watchdog_reset_enable_r;
  logic watchdog_restart_r;

  logic watchdog_run_nxt;
  logic interval_select_hi_nxt;
  logic interval_select_lo_nxt;
  logic watchdog_irq_flag_nxt;
  logic watchdog_reset_cause_flag_nxt;
  logic watchdog_reset_enable_nxt;
  logic watchdog_restart_nxt;

  logic irq_r;
  logic wdt_reset_r;
  wdc_byte_t rdata_r;
  localparam wdc_byte_t CTRL_RST = `WDC_CTRL_RESET;

  logic timeout;
  logic expire;
  logic key_open;

  // Soft reset sources
  wire ext_rst = ~ext_s2_r;
  wire pf_rst = pf_s2_r;

  wire wdt_fire = expire & watchdog_reset_enable_r;
  wire any_soft = ext_rst | pf_rst | wdt_fire;

  wire hit_ctrl = (sfr_addr == `WDC_ADDR_CTRL);
  wire hit_key = (sfr_addr == `WDC_ADDR_KEY);
  wire wr_ctrl = sfr_wr & hit_ctrl & ~any_soft;
  wire wr_key = sfr_wr & hit_key;

  // protected write qualified by key window
  wire prot_wr = wr_ctrl & key_open;

  // full readback, reserved bit reads zero
  wire [7:0] ctrl_val = {watchdog_run_r, 1'b0, interval_select_hi_r, interval_select_lo_r,
                         watchdog_irq_flag_r, watchdog_reset_cause_flag_r,
                         watchdog_reset_enable_r, watchdog_restart_r};
  wire [7:0] rdata_nxt = (sfr_rd & hit_ctrl) ? ctrl_val : 8'h00;

  assign watchdog_run_nxt = any_soft ? 1'b0 :
                            wr_ctrl ? sfr_wdata[`WDC_BIT_RUN] : watchdog_run_r;

  assign interval_select_hi_nxt = any_soft ? 1'b0 :
                                  wr_ctrl ? sfr_wdata[`WDC_BIT_SEL_HI] : interval_select_hi_r;
  assign interval_select_lo_nxt = any_soft ? 1'b0 :
                                  wr_ctrl ? sfr_wdata[`WDC_BIT_SEL_LO] : interval_select_lo_r;

  // time-out sets flag, set wins over software clear
  // external reset does not touch the flag
  assign watchdog_irq_flag_nxt = (pf_rst | wdt_fire) ? 1'b0 :
                                 timeout ? 1'b1 :
                                 prot_wr ? sfr_wdata[`WDC_BIT_IRQ_FLAG] : watchdog_irq_flag_r;

  // set on watchdog reset, cleared by software or power-fail reset
  assign watchdog_reset_cause_flag_nxt = pf_rst ? 1'b0 :
                                         wdt_fire ? 1'b1 :
                                         wr_ctrl ? sfr_wdata[`WDC_BIT_CAUSE] :
                                         watchdog_reset_cause_flag_r;

  // reset enable survives all soft resets
  assign watchdog_reset_enable_nxt = prot_wr ? sfr_wdata[`WDC_BIT_RST_EN] : watchdog_reset_enable_r;

  assign watchdog_restart_nxt = prot_wr & sfr_wdata[`WDC_BIT_RESTART];

  // Synchronise pin reset sources
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      pf_s1_r <= 1'b0;
      pf_s2_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= ext_reset_n;
      ext_s2_r <= ext_s1_r;
      pf_s1_r <= power_fail;
      pf_s2_r <= pf_s1_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      watchdog_run_r <= CTRL_RST[`WDC_BIT_RUN];
      interval_select_hi_r <= CTRL_RST[`WDC_BIT_SEL_HI];
      interval_select_lo_r <= CTRL_RST[`WDC_BIT_SEL_LO];
      watchdog_irq_flag_r <= CTRL_RST[`WDC_BIT_IRQ_FLAG];
      watchdog_reset_cause_flag_r <= CTRL_RST[`WDC_BIT_CAUSE];
      watchdog_reset_enable_r <= CTRL_RST[`WDC_BIT_RST_EN];
      watchdog_restart_r <= CTRL_RST[`WDC_BIT_RESTART];
    end
    else
    begin
      watchdog_run_r <= watchdog_run_nxt;
      interval_select_hi_r <= interval_select_hi_nxt;
      interval_select_lo_r <= interval_select_lo_nxt;
      watchdog_irq_flag_r <= watchdog_irq_flag_nxt;
      watchdog_reset_cause_flag_r <= watchdog_reset_cause_flag_nxt;
      watchdog_reset_enable_r <= watchdog_reset_enable_nxt;
      watchdog_restart_r <= watchdog_restart_nxt;
    end
  end

  // Output flops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_r <= 1'b0;
      wdt_reset_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      irq_r <= watchdog_irq_flag_nxt & watchdog_irq_enable;
      wdt_reset_r <= wdt_fire;
      rdata_r <= rdata_nxt;
    end
  end

  assign watchdog_irq = irq_r;
  assign watchdog_reset = wdt_reset_r;
  assign sfr_rdata = rdata_r;

  // Counter restarts on software restart or any soft reset
  wire tmr_restart = watchdog_restart_r | any_soft;

  wdc_timer #(
    .EXP0(EXP0),
    .EXP1(EXP1),
    .EXP2(EXP2),
    .EXP3(EXP3),
    .DELAY(DELAY)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(watchdog_run_r),
    .restart(tmr_restart),
    .sel({interval_select_hi_r, interval_select_lo_r}),
    .timeout(timeout),
    .expire(expire)
  );

  wdc_key_gate #(
    .WINDOW(WINDOW)
  ) u_key (
    .sys_clk(sys_clk),
    .rst(rst),
    .key_wr(wr_key),
    .wdata(sfr_wdata),
    .consume(prot_wr),
    .open(key_open)
  );

  // Running cycles after the time-out pulse, checks only
  logic [15:0] since_to_r;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      since_to_r <= 16'h0000;
    end
    else if (timeout)
    begin
      since_to_r <= 16'h0000;
    end
    else if (watchdog_run_r && since_to_r != 16'hFFFF)
    begin
      since_to_r <= since_to_r + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  halt_events_a: assert property (!watchdog_run_r && !$past(watchdog_run_r) |-> !timeout && !expire)
    else $error("timer event while stopped");

  flag_set_a: assert property (timeout && !pf_rst && !wdt_fire |=> watchdog_irq_flag_r)
    else $error("time-out did not set interrupt flag");

  flag_hold_a: assert property (watchdog_irq_flag_r && !prot_wr && !pf_rst && !wdt_fire |=> watchdog_irq_flag_r)
    else $error("interrupt flag cleared without software");

  cause_set_a: assert property (wdt_fire && !pf_rst |=> watchdog_reset_cause_flag_r ##1 watchdog_reset_cause_flag_r)
    else $error("reset cause not recorded");

  cause_pf_a: assert property (pf_rst |=> !watchdog_reset_cause_flag_r)
    else $error("power-fail did not clear cause flag");

  cause_keep_a: assert property (!watchdog_reset_enable_r && !wr_ctrl && !pf_rst |=> $stable(watchdog_reset_cause_flag_r))
    else $error("cause flag changed with reset disabled");

  no_reset_a: assert property (!watchdog_reset_enable_r |=> !watchdog_reset)
    else $error("reset issued while disabled");

  restart_self_a: assert property (watchdog_restart_r |=> !watchdog_restart_r)
    else $error("restart bit not self-cleared");

  reset_delay_a: assert property (expire |-> since_to_r == 16'(DELAY - 1))
    else $error("reset delay after time-out wrong");

  ext_flag_a: assert property (ext_rst && !timeout && !prot_wr && !pf_rst && !wdt_fire |=> $stable(watchdog_irq_flag_r))
    else $error("external reset changed interrupt flag");

  enable_keep_a: assert property (!prot_wr |=> $stable(watchdog_reset_enable_r))
    else $error("reset enable changed without protected write");

  locked_write_a: assert property (wr_ctrl && !key_open |=> $stable(watchdog_reset_enable_r) && !watchdog_restart_r)
    else $error("protected bit written without key");

  read_back_a: assert property (sfr_rd && hit_ctrl |=> sfr_rdata == $past(ctrl_val) && !sfr_rdata[`WDC_BIT_RSVD])
    else $error("control register readback wrong");

  irq_gate_a: assert property (!watchdog_irq_enable |=> !watchdog_irq)
    else $error("interrupt raised while disabled");

endmodule

/* sim/test_wdc_top.sv */
`timescale 1ns/1ps
`include "wdc_defs.svh"

module test_wdc_top
  import wdc_pkg::*;
;
  localparam int E0 = 3;
  localparam int E1 = 4;
  localparam int E2 = 5;
  localparam int E3 = 6;
  localparam int DLY = 8;

  typedef struct packed {
    logic prot;
    wdc_byte_t data;
    wdc_byte_t exp;
  } wdc_row_s;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic ext_reset_n = 1'b1;
  logic power_fail = 1'b0;
  logic watchdog_irq_enable = 1'b0;
  wdc_byte_t sfr_addr = 8'h00;
  wdc_byte_t sfr_wdata = 8'h00;
  wdc_byte_t sfr_rdata;
  logic watchdog_irq;
  logic watchdog_reset;
  int errors = 0;
  int cmp_count = 0;
  int n;
  int ex[4] = '{E0, E1, E2, E3};
  // Ordinary and protected writes with their readback
  wdc_row_s rows[6] = '{'{1'b0, 8'h30, 8'h30}, '{1'b0, 8'h7F, 8'h34}, '{1'b0, 8'h00, 8'h00},
                        '{1'b1, 8'h02, 8'h02}, '{1'b1, 8'h08, 8'h08}, '{1'b1, 8'h00, 8'h00}};

  always #25 sys_clk = ~sys_clk;

  wdc_top #(.EXP0(E0), .EXP1(E1), .EXP2(E2), .EXP3(E3), .DELAY(DLY), .WINDOW(3)) dut_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .ext_reset_n(ext_reset_n),
    .power_fail(power_fail),
    .watchdog_irq_enable(watchdog_irq_enable),
    .watchdog_irq(watchdog_irq),
    .watchdog_reset(watchdog_reset)
  );

  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Strobe stays up until idle or the next write
  task wr(input wdc_byte_t a, input wdc_byte_t d);
    @(posedge sys_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
  endtask

  task idle;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
  endtask

  task pw(input wdc_byte_t d);
    wr(`WDC_ADDR_CTRL, d);
    idle();
  endtask

  // Key sequence then the protected write, back to back
  task pwr(input wdc_byte_t d);
    wr(`WDC_ADDR_KEY, `WDC_KEY_FIRST);
    wr(`WDC_ADDR_KEY, `WDC_KEY_SECOND);
    pw(d);
  endtask

  task rd(input wdc_byte_t a, input wdc_byte_t e);
    @(posedge sys_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1;
    check(sfr_rdata, e);
  endtask

  // Cycles until irq (which=0) or reset pulse (which=1), capped at 300
  task wait_ev(input logic which, output int c);
    c = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      c++;
    end
    while ((which ? watchdog_reset : watchdog_irq) !== 1'b1 && c < 300);
  endtask

  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`WDC_ADDR_CTRL, `WDC_CTRL_RESET);
    rd(`WDC_ADDR_KEY, 8'h00);
    rd(8'hD9, 8'h00);
    foreach (rows[i])
    begin
      if (rows[i].prot)
        pwr(rows[i].data);
      else
        pw(rows[i].data);
      rd(`WDC_ADDR_CTRL, rows[i].exp);
    end
    watchdog_irq_enable <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      pwr(8'h01);
      pw(8'h80 | 8'(s << 4));
      wait_ev(1'b0, n);
      check(8'(n >= (1 << ex[s]) && n <= (1 << ex[s]) + 3), 8'h01);
    end
    watchdog_irq_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check(watchdog_irq, 1'b0);
    wait_ev(1'b1, n);
    check(8'(n >= 300), 8'h01);
    rd(`WDC_ADDR_CTRL, 8'hB8);
    pwr(8'h01);
    repeat (100) @(posedge sys_clk);
    rd(`WDC_ADDR_CTRL, 8'h00);
    // Timed-out watchdog with reset enabled
    watchdog_irq_enable <= 1'b1;
    pwr(8'h03);
    pw(8'h80);
    wait_ev(1'b0, n);
    wait_ev(1'b1, n);
    check(8'(n), 8'(DLY));
    @(posedge sys_clk);
    #1;
    check(watchdog_reset, 1'b0);
    rd(`WDC_ADDR_CTRL, 8'h06);
    // Restart in the delay pushes the reset out by a full period
    pw(8'h84);
    wait_ev(1'b0, n);
    pwr(8'h87);
    wait_ev(1'b1, n);
    check(8'(n >= (1 << E0) + DLY && n <= (1 << E0) + DLY + 3), 8'h01);
    rd(`WDC_ADDR_CTRL, 8'h06);
    pwr(8'hBE);
    rd(`WDC_ADDR_CTRL, 8'hBE);
    ext_reset_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ext_reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(`WDC_ADDR_CTRL, 8'h0E);
    power_fail <= 1'b1;
    repeat (4) @(posedge sys_clk);
    power_fail <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(`WDC_ADDR_CTRL, 8'h02);
    // Window lapsed, then a wrong second key
    wr(`WDC_ADDR_KEY, `WDC_KEY_FIRST);
    wr(`WDC_ADDR_KEY, `WDC_KEY_SECOND);
    idle();
    repeat (5) @(posedge sys_clk);
    pw(8'h00);
    rd(`WDC_ADDR_CTRL, 8'h02);
    wr(`WDC_ADDR_KEY, `WDC_KEY_FIRST);
    wr(`WDC_ADDR_KEY, 8'h12);
    pw(8'h00);
    rd(`WDC_ADDR_CTRL, 8'h02);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`WDC_ADDR_CTRL, `WDC_CTRL_RESET);
    test_done();
  end

  initial
  begin
    #400_000;
    errors++;
    test_done();
  end
endmodule
